// *** pesc_chk.sv ***
`timescale 1ns/100ps
module pesc_chk
    import pesc_pkg::*;
#(
    parameter int SUSP_CYC = SUSPEND_CYC,
    parameter int RES_CYC  = RESUME_CYC
) (
    input wire logic         i_core_clk,
    input wire logic         i_rst_n,
    input wire logic         i_cmd_valid,
    input wire pesc_cmd_e    i_cmd_class,
    input wire logic         o_cmd_accept,
    input wire logic         o_cmd_reject,
    input wire logic         o_prog_abort,
    input wire logic         o_rd_undefined,
    input wire logic         o_op_halt,
    input wire logic         o_op_resume,
    input wire pesc_op_s     o_resume_desc,
    input wire pesc_status_s o_status,
    input wire logic         o_lost_erase,
    input wire logic         o_lost_prog
);
    localparam int SUSP_HI = SUSP_CYC + 2;
    logic held;
    assign held = o_status.es | o_status.ps1 | o_status.ps2;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // Command gating
    // ----------------------------------------
    a_cmd_one_hot: assert property (
        i_cmd_valid |-> $onehot({o_cmd_accept, o_cmd_reject, o_prog_abort}))
        else $error("command outcome not one-hot");
    a_erase_rejected: assert property (
        i_cmd_valid && held && i_cmd_class inside {CMD_B1_PROG_ERASE, CMD_B2_PROG_ERASE,
        CMD_THRU_B1_ERASE, CMD_THRU_B2_ERASE, CMD_AUTO_REWRITE, CMD_PAGE_ERASE,
        CMD_BLOCK_ERASE, CMD_SECTOR_ERASE, CMD_CHIP_ERASE} |-> o_cmd_reject)
        else $error("erase command not rejected while suspended");
    a_prot_rejected: assert property (
        i_cmd_valid && held && i_cmd_class inside {CMD_PROT_CHANGE, CMD_POWER_DOWN}
        |-> o_cmd_reject) else $error("protection or power command not rejected");
    a_reads_accepted: assert property (
        i_cmd_valid && i_cmd_class inside {CMD_READ_ARRAY, CMD_READ_BUF1, CMD_READ_BUF2,
        CMD_STATUS_READ, CMD_INFO_READ, CMD_PROT_READ} |-> o_cmd_accept)
        else $error("read command not accepted");
    a_abort_in_erase: assert property (
        o_prog_abort |-> i_cmd_valid && o_status.es)
        else $error("program abort outside erase suspend");
    // ----------------------------------------
    // Suspend and resume
    // ----------------------------------------
    a_halt_to_ready: assert property (
        o_op_halt |-> !o_status.ready ##1 !o_op_halt ##[0:SUSP_HI] o_status.ready)
        else $error("suspend did not complete in time");
    a_flag_one_ready: assert property (
        ($rose(o_status.ps1) || $rose(o_status.ps2) || $rose(o_status.es)) |->
        o_status.ready && $onehot({$rose(o_status.ps1), $rose(o_status.ps2),
        $rose(o_status.es)})) else $error("suspend flags or ready wrong");
    a_resume_busy: assert property (
        o_op_resume |-> !o_status.ready && ($fell(o_status.ps1) || $fell(o_status.ps2)
        || $fell(o_status.es))) else $error("resume did not clear flag or go busy");
    a_prog_first: assert property (
        o_op_resume && $past(o_status.es) && $past(o_status.ps1 || o_status.ps2) |->
        o_resume_desc.kind inside {OP_PROG_B1, OP_PROG_B2} && o_status.es)
        else $error("erase resumed before program");
    a_lost_clears: assert property (
        o_lost_erase || o_lost_prog |-> !held && o_status.ready)
        else $error("reset abort left flags set");
    a_undef_held: assert property (
        o_rd_undefined |-> $past(held)) else $error("undefined read with nothing held");
    c_both_held: cover property (o_status.es && o_status.ps1);
    c_abort: cover property (o_prog_abort);
    c_lost: cover property (o_lost_erase);
endmodule

// *** pesc_ctrl.sv ***
`timescale 1ns/100ps
module pesc_ctrl
    import pesc_pkg::*;
#(
    parameter int SUSP_CYC = SUSPEND_CYC,
    parameter int RES_CYC  = RESUME_CYC
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_spi_sck,
    input  wire logic                i_spi_cs_n,
    input  wire logic                i_spi_mosi,
    input  wire logic                i_reset_pin_n,
    input  wire logic                i_sw_reset,
    input  wire logic                i_op_start,
    input  wire pesc_op_s            i_op_desc,
    input  wire logic                i_op_done,
    input  wire logic                i_cmd_valid,
    input  wire pesc_cmd_e           i_cmd_class,
    input  wire logic [SECTOR_W-1:0] i_cmd_sector,
    input  wire logic [SECTOR_W-1:0] i_rd_sector,
    output logic                     o_cmd_accept,
    output logic                     o_cmd_reject,
    output logic                     o_prog_abort,
    output logic                     o_rd_undefined,
    output logic                     o_op_halt,
    output logic                     o_op_resume,
    output pesc_op_s                 o_resume_desc,
    output pesc_status_s             o_status,
    output logic                     o_lost_erase,
    output logic                     o_lost_prog,
    output pesc_lost_s               o_lost_erase_region,
    output pesc_lost_s               o_lost_prog_region
);
    if (SUSP_CYC < 1 || SUSP_CYC >= (1 << CNT_W) || RES_CYC < 1 || RES_CYC >= (1 << CNT_W)) begin
        $error("latency counts out of range");
    end

    //--------------------------------------------------------------
    // Pin sampling and opcode capture
    //--------------------------------------------------------------
    logic [3:0] pins;
    logic       sck;
    logic       cs_n;
    logic       mosi;
    logic       rst_pin_n;

    pesc_sync #(.W(4)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_spi_sck, i_spi_cs_n, i_spi_mosi, i_reset_pin_n}),
        .o_level    (pins)
    );
    assign {sck, cs_n, mosi, rst_pin_n} = pins;

    logic       sck_d, cs_d, rstp_d;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic       op_got;
    logic [7:0] opcode;
    logic       next_sck_d, next_cs_d, next_rstp_d;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shift;
    logic       next_op_got;
    logic [7:0] next_opcode;
    logic       cs_rise;
    logic       susp_req;
    logic       res_req;
    logic       hw_reset;

    always_comb begin
        next_sck_d   = sck;
        next_cs_d    = cs_n;
        next_rstp_d  = rst_pin_n;
        next_bit_cnt = bit_cnt;
        next_shift   = shift;
        next_op_got  = op_got;
        next_opcode  = opcode;
        if (cs_n) begin
            next_bit_cnt = 3'h0;
            next_op_got  = 1'b0;
        end else if (sck && !sck_d && !op_got) begin
            // Only the first byte matters; the rest are dropped
            next_shift   = {shift[6:0], mosi};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                next_op_got = 1'b1;
                next_opcode = {shift[6:0], mosi};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            sck_d   <= 1'b1;
            cs_d    <= 1'b1;
            rstp_d  <= 1'b1;
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
            op_got  <= 1'b0;
            opcode  <= 8'h00;
        end else begin
            sck_d   <= next_sck_d;
            cs_d    <= next_cs_d;
            rstp_d  <= next_rstp_d;
            bit_cnt <= next_bit_cnt;
            shift   <= next_shift;
            op_got  <= next_op_got;
            opcode  <= next_opcode;
        end
    end

    assign cs_rise  = cs_n && !cs_d;
    assign susp_req = cs_rise && op_got && (opcode == OPC_SUSPEND);
    assign res_req  = cs_rise && op_got && (opcode == OPC_RESUME);
    assign hw_reset = !rst_pin_n && rstp_d;

    //--------------------------------------------------------------
    // Operation and suspend state
    //--------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSPENDING, ST_RESUMING} pesc_state_e;

    pesc_state_e      state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    pesc_op_s         run, next_run;
    logic             es_held, next_es_held;
    pesc_op_s         es_op, next_es_op;
    logic             pg_held, next_pg_held;
    pesc_op_s         pg_op, next_pg_op;
    logic             halt_p, next_halt_p;
    logic             resume_p, next_resume_p;
    pesc_op_s         next_resume_desc;
    logic             lost_e, next_lost_e;
    logic             lost_p, next_lost_p;
    pesc_lost_s       next_lost_er, next_lost_pr;
    logic             rd_undef, next_rd_undef;
    logic             run_is_prog;

    assign run_is_prog = (run.kind == OP_PROG_B1) || (run.kind == OP_PROG_B2);

    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_run         = run;
        next_es_held     = es_held;
        next_es_op       = es_op;
        next_pg_held     = pg_held;
        next_pg_op       = pg_op;
        next_halt_p      = 1'b0;
        next_resume_p    = 1'b0;
        next_resume_desc = o_resume_desc;
        next_lost_e      = 1'b0;
        next_lost_p      = 1'b0;
        next_lost_er     = o_lost_erase_region;
        next_lost_pr     = o_lost_prog_region;
        unique case (state)
            ST_IDLE: begin
                if (i_op_start) begin
                    next_state = ST_RUN;
                    next_run   = i_op_desc;
                end else if (res_req && pg_held) begin
                    // Program resumes ahead of a held erase
                    next_state       = ST_RESUMING;
                    next_cnt         = CNT_W'(RES_CYC - 1);
                    next_run         = pg_op;
                    next_pg_held     = 1'b0;
                    next_resume_p    = 1'b1;
                    next_resume_desc = pg_op;
                end else if (res_req && es_held) begin
                    next_state       = ST_RESUMING;
                    next_cnt         = CNT_W'(RES_CYC - 1);
                    next_run         = es_op;
                    next_es_held     = 1'b0;
                    next_resume_p    = 1'b1;
                    next_resume_desc = es_op;
                end
            end
            ST_RUN: begin
                if (i_op_done) begin
                    next_state = ST_IDLE;
                end else if (susp_req && !(run_is_prog ? pg_held : es_held)) begin
                    next_state  = ST_SUSPENDING;
                    next_cnt    = CNT_W'(SUSP_CYC - 1);
                    next_halt_p = 1'b1;
                end
            end
            ST_SUSPENDING: begin
                if (i_op_done) begin
                    next_state = ST_IDLE;
                end else if (cnt == '0) begin
                    next_state = ST_IDLE;
                    if (run_is_prog) begin
                        next_pg_held = 1'b1;
                        next_pg_op   = run;
                    end else begin
                        next_es_held = 1'b1;
                        next_es_op   = run;
                    end
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            ST_RESUMING: begin
                // Suspend requests fall through unheard here
                if (i_op_done) begin
                    next_state = ST_IDLE;
                end else if (cnt == '0) begin
                    next_state = ST_RUN;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
        endcase
        if (i_sw_reset || hw_reset) begin
            if (es_held) begin
                next_lost_e  = 1'b1;
                next_lost_er = '{whole_sector: es_op.kind == OP_ERASE_SECTOR,
                                 sector: es_op.sector, page: es_op.page};
            end
            if (pg_held) begin
                next_lost_p  = 1'b1;
                next_lost_pr = '{whole_sector: 1'b0,
                                 sector: pg_op.sector, page: pg_op.page};
            end
            next_state   = ST_IDLE;
            next_es_held = 1'b0;
            next_pg_held = 1'b0;
        end
        next_rd_undef = (es_held && i_rd_sector == es_op.sector)
                     || (pg_held && i_rd_sector == pg_op.sector);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state               <= ST_IDLE;
            cnt                 <= '0;
            run                 <= '0;
            es_held             <= 1'b0;
            es_op               <= '0;
            pg_held             <= 1'b0;
            pg_op               <= '0;
            halt_p              <= 1'b0;
            resume_p            <= 1'b0;
            o_resume_desc       <= '0;
            lost_e              <= 1'b0;
            lost_p              <= 1'b0;
            o_lost_erase_region <= '0;
            o_lost_prog_region  <= '0;
            rd_undef            <= 1'b0;
        end else begin
            state               <= next_state;
            cnt                 <= next_cnt;
            run                 <= next_run;
            es_held             <= next_es_held;
            es_op               <= next_es_op;
            pg_held             <= next_pg_held;
            pg_op               <= next_pg_op;
            halt_p              <= next_halt_p;
            resume_p            <= next_resume_p;
            o_resume_desc       <= next_resume_desc;
            lost_e              <= next_lost_e;
            lost_p              <= next_lost_p;
            o_lost_erase_region <= next_lost_er;
            o_lost_prog_region  <= next_lost_pr;
            rd_undef            <= next_rd_undef;
        end
    end

    assign o_op_halt      = halt_p;
    assign o_op_resume    = resume_p;
    assign o_lost_erase   = lost_e;
    assign o_lost_prog    = lost_p;
    assign o_rd_undefined = rd_undef;
    assign o_status       = '{ready: state == ST_IDLE, es: es_held,
                              ps2: pg_held && pg_op.kind == OP_PROG_B2,
                              ps1: pg_held && pg_op.kind == OP_PROG_B1};

    //--------------------------------------------------------------
    // Command gating while suspended
    //--------------------------------------------------------------
    logic ps1, ps2, any_susp, allow, is_prog;

    assign ps1      = o_status.ps1;
    assign ps2      = o_status.ps2;
    assign any_susp = es_held || pg_held;

    always_comb begin
        allow   = 1'b1;
        is_prog = 1'b0;
        unique case (i_cmd_class)
            CMD_READ_ARRAY, CMD_READ_BUF1, CMD_READ_BUF2: allow = 1'b1;
            CMD_STATUS_READ, CMD_INFO_READ:                allow = 1'b1;
            CMD_PROT_READ:                                 allow = 1'b1;
            CMD_BUF1_WRITE, CMD_XFER_B1:                   allow = !ps1;
            CMD_BUF2_WRITE, CMD_XFER_B2:                   allow = !ps2;
            CMD_CMP_B1:                                    allow = !ps1;
            CMD_CMP_B2:                                    allow = !ps2;
            CMD_B1_PROG_NOERASE, CMD_B2_PROG_NOERASE: begin
                allow   = !pg_held;
                is_prog = 1'b1;
            end
            CMD_THRU_B1_NOERASE: begin
                allow   = !pg_held;
                is_prog = 1'b1;
            end
            CMD_B1_PROG_ERASE, CMD_B2_PROG_ERASE, CMD_THRU_B1_ERASE, CMD_THRU_B2_ERASE,
            CMD_AUTO_REWRITE, CMD_PAGE_ERASE, CMD_BLOCK_ERASE, CMD_SECTOR_ERASE,
            CMD_CHIP_ERASE:                                allow = !any_susp;
            CMD_PROT_CHANGE:                               allow = !any_susp;
            CMD_POWER_DOWN:                                allow = !any_susp;
        endcase
    end

    // Refusals touch no state; flags stay put
    assign o_prog_abort = i_cmd_valid && allow && is_prog && es_held
                       && (i_cmd_sector == es_op.sector);
    assign o_cmd_accept = i_cmd_valid && allow && !o_prog_abort;
    assign o_cmd_reject = i_cmd_valid && !allow;
endmodule

// *** pesc_host_model.sv ***
`timescale 1ns/100ps
module pesc_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end
    // One frame: opcode MSB first, optional trailing byte, clock still outside
    task automatic frame(input logic [7:0] op, input logic extra);
        logic [15:0] sh;
        int          n;
        sh = {op, ~op};
        n = extra ? 16 : 8;
        // Idle gap first, so the call returns as chip select rises
        #400;
        o_cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            o_mosi = sh[15-i];
            #100;
            o_sck = 1'b1;
            #100;
            o_sck = 1'b0;
        end
        #100;
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
    endtask
endmodule

// *** pesc_pkg.sv ***
// Functional notes
// - Chip select rising after suspend opcode halts the running operation within latency.
// - Suspend sets one flag: buffer-one program, buffer-two program, or erase.
// - Once suspended the ready flag reports ready.
// - Suspend covers one 128KB sector; other sectors remain usable.
// - Erase suspend accepts reads and programs to other sectors.
// - Host must not read a suspended sector; such reads give undefined data.
// - Continuous read in a suspended sector outputs undefined data until leaving it.
// - Program aimed at the erase-suspended sector is aborted.
// - Program started during erase suspend may itself be suspended; both flags set.
// - Reset during sector erase suspend aborts it; whole sector undefined.
// - Reset during page-level suspend aborts it; only that page undefined.
// - Array and buffer reads are accepted in every suspend state.
// - Write, load or compare on the suspended program's buffer is rejected.
// - Buffer compare refused on suspended program's buffer, allowed otherwise.
// - Buffer-to-memory program without erase allowed only in erase suspend.
// - Program through buffer one without erase allowed only in erase suspend.
// - Every erase-containing command is rejected in any suspend state.
// - Protection and security changing commands are rejected in any suspend state.
// - Protection, lockdown and security register reads are accepted while suspended.
// - Status register reads stay serviced while suspended.
// - Resume opcode D0h restarts within latency, clears flag, reports busy.
// - With both suspended, first resume restarts program, second restarts erase.
// - Power-down entry and exit commands are refused while suspended.
// - Suspend is ignored while a resumed operation is still restarting.
package pesc_pkg;

    localparam logic [7:0] OPC_SUSPEND = 8'hB0;
    localparam logic [7:0] OPC_RESUME  = 8'hD0;

    localparam int CLK_MHZ            = 40;
    localparam int SUSPEND_LATENCY_US = 60;
    localparam int RESUME_LATENCY_US  = 60;
    // Longest times: whole cycles rounded down
    localparam int SUSPEND_CYC        = SUSPEND_LATENCY_US * CLK_MHZ;
    localparam int RESUME_CYC         = RESUME_LATENCY_US * CLK_MHZ;

    localparam int SECTOR_W = 4;
    localparam int PAGE_W   = 12;
    localparam int CNT_W    = 12;

    typedef enum logic [2:0] {
        OP_PROG_B1,
        OP_PROG_B2,
        OP_ERASE_PAGE,
        OP_ERASE_BLOCK,
        OP_ERASE_SECTOR
    } pesc_op_e;

    typedef enum logic [4:0] {
        CMD_READ_ARRAY, CMD_READ_BUF1, CMD_READ_BUF2, CMD_STATUS_READ,
        CMD_INFO_READ, CMD_PROT_READ, CMD_BUF1_WRITE, CMD_BUF2_WRITE,
        CMD_B1_PROG_ERASE, CMD_B2_PROG_ERASE, CMD_B1_PROG_NOERASE,
        CMD_B2_PROG_NOERASE, CMD_THRU_B1_ERASE, CMD_THRU_B2_ERASE,
        CMD_THRU_B1_NOERASE, CMD_AUTO_REWRITE, CMD_PAGE_ERASE, CMD_BLOCK_ERASE,
        CMD_SECTOR_ERASE, CMD_CHIP_ERASE, CMD_PROT_CHANGE, CMD_XFER_B1,
        CMD_XFER_B2, CMD_CMP_B1, CMD_CMP_B2, CMD_POWER_DOWN
    } pesc_cmd_e;

    typedef struct packed {
        pesc_op_e            kind;
        logic [SECTOR_W-1:0] sector;
        logic [PAGE_W-1:0]   page;
    } pesc_op_s;

    typedef struct packed {
        logic ready;
        logic es;
        logic ps2;
        logic ps1;
    } pesc_status_s;

    typedef struct packed {
        logic                whole_sector;
        logic [SECTOR_W-1:0] sector;
        logic [PAGE_W-1:0]   page;
    } pesc_lost_s;

endpackage

// *** pesc_sync.sv ***
`timescale 1ns/100ps
module pesc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] meta;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    // Change accepted once second and third stages agree
    always_comb begin
        for (int b = 0; b < W; b++) begin
            next_level[b] = (s2[b] == s3[b]) ? s3[b] : o_level[b];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            meta    <= '1;
            s2      <= '1;
            s3      <= '1;
            o_level <= '1;
        end else begin
            meta    <= i_async;
            s2      <= meta;
            s3      <= s2;
            o_level <= next_level;
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import pesc_pkg::*;
    localparam logic [2:0] A = 3'h1;
    localparam logic [2:0] R = 3'h2;
    localparam pesc_cmd_e TC [22] = '{CMD_READ_ARRAY, CMD_READ_BUF2, CMD_STATUS_READ,
        CMD_INFO_READ, CMD_PROT_READ, CMD_BUF1_WRITE, CMD_BUF2_WRITE, CMD_B1_PROG_NOERASE,
        CMD_B2_PROG_NOERASE, CMD_THRU_B1_NOERASE, CMD_XFER_B1, CMD_CMP_B1, CMD_CMP_B2,
        CMD_B1_PROG_ERASE, CMD_THRU_B2_ERASE, CMD_AUTO_REWRITE, CMD_PAGE_ERASE,
        CMD_BLOCK_ERASE, CMD_SECTOR_ERASE, CMD_CHIP_ERASE, CMD_PROT_CHANGE, CMD_POWER_DOWN};
    localparam pesc_cmd_e BC [10] = '{CMD_BUF1_WRITE, CMD_BUF2_WRITE, CMD_XFER_B1,
        CMD_XFER_B2, CMD_CMP_B1, CMD_CMP_B2, CMD_B2_PROG_NOERASE, CMD_THRU_B1_NOERASE,
        CMD_READ_BUF1, CMD_SECTOR_ERASE};
    localparam logic [2:0] BX [10] = '{R, A, R, A, R, A, R, R, A, R};
    logic                i_core_clk, i_rst_n, i_spi_sck, i_spi_cs_n, i_spi_mosi;
    logic                i_reset_pin_n, i_sw_reset, i_op_start, i_op_done, i_cmd_valid;
    pesc_op_s            i_op_desc, o_resume_desc;
    pesc_cmd_e           i_cmd_class;
    logic [SECTOR_W-1:0] i_cmd_sector, i_rd_sector;
    logic                o_cmd_accept, o_cmd_reject, o_prog_abort, o_rd_undefined;
    logic                o_op_halt, o_op_resume, o_lost_erase, o_lost_prog;
    pesc_status_s        o_status;
    pesc_lost_s          o_lost_erase_region, o_lost_prog_region;
    int                  n_fail, cmp_count;

    pesc_ctrl #(.SUSP_CYC(4), .RES_CYC(200)) dut_u (.i_core_clk, .i_rst_n, .i_spi_sck,
        .i_spi_cs_n, .i_spi_mosi, .i_reset_pin_n, .i_sw_reset, .i_op_start, .i_op_desc,
        .i_op_done, .i_cmd_valid, .i_cmd_class, .i_cmd_sector, .i_rd_sector, .o_cmd_accept,
        .o_cmd_reject, .o_prog_abort, .o_rd_undefined, .o_op_halt, .o_op_resume,
        .o_resume_desc, .o_status, .o_lost_erase, .o_lost_prog, .o_lost_erase_region,
        .o_lost_prog_region);
    pesc_host_model host_u (.o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n), .o_mosi(i_spi_mosi));

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_for(input int sel, input int bound, input bit must);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < bound && !seen; i++) begin
            @(negedge i_core_clk);
            seen = (sel == 0) ? (o_op_halt === 1'b1) : (sel == 1) ? (o_op_resume === 1'b1)
                 : (o_lost_erase === 1'b1);
        end
        check($sformatf("event %0d", sel), 20'(must), 20'(seen));
        if (must && !seen) begin
            test_done();
        end
    endtask
    task automatic start(input pesc_op_e k, input logic [3:0] s, input logic [11:0] p);
        @(negedge i_core_clk);
        i_op_start = 1'b1;
        i_op_desc = '{k, s, p};
        @(negedge i_core_clk);
        i_op_start = 1'b0;
    endtask
    task automatic susp(input logic [19:0] exp_st);
        host_u.frame(OPC_SUSPEND, 1'b1);
        wait_for(0, 300, 1'b1);
        check("ready at halt", 20'h0, 20'(o_status.ready));
        repeat (6) @(negedge i_core_clk);
        check("status", exp_st, 20'(o_status));
    endtask
    task automatic cmd(input pesc_cmd_e c, input logic [3:0] s, input logic [2:0] exp);
        @(negedge i_core_clk);
        i_cmd_valid = 1'b1;
        i_cmd_class = c;
        i_cmd_sector = s;
        #1;
        check(c.name(), 20'(exp), 20'({o_prog_abort, o_cmd_reject, o_cmd_accept}));
        @(negedge i_core_clk);
        i_cmd_valid = 1'b0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {i_rst_n, i_sw_reset, i_op_start, i_op_done, i_cmd_valid} = '0;
        {i_op_desc, i_cmd_sector, i_rd_sector} = '0;
        i_reset_pin_n = 1'b1;
        i_cmd_class = CMD_READ_ARRAY;
        n_fail = 0;
        cmp_count = 0;
        repeat (4) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        repeat (5) @(negedge i_core_clk);
        check("reset status", 20'h8, 20'(o_status));
        start(OP_ERASE_SECTOR, 4'h3, 12'h040);
        susp(20'hC);
        for (int s = 2; s < 5; s++) begin
            i_rd_sector = 4'(s);
            repeat (2) @(negedge i_core_clk);
            check("rd undefined", 20'(s == 3), 20'(o_rd_undefined));
        end
        foreach (TC[i]) cmd(TC[i], 4'h5, (i < 13) ? A : R);
        cmd(CMD_B1_PROG_NOERASE, 4'h3, 3'h4);
        cmd(CMD_THRU_B1_NOERASE, 4'h3, 3'h4);
        start(OP_PROG_B1, 4'h5, 12'h007);
        susp(20'hD);
        foreach (BC[i]) cmd(BC[i], 4'h5, BX[i]);
        check("status kept", 20'hD, 20'(o_status));
        host_u.frame(OPC_RESUME, 1'b0);
        wait_for(1, 300, 1'b1);
        check("resume desc", 20'({OP_PROG_B1, 4'h5, 12'h007}), 20'(o_resume_desc));
        check("resume status", 20'h4, 20'(o_status));
        host_u.frame(OPC_SUSPEND, 1'b0);
        wait_for(0, 20, 1'b0);
        i_op_done = 1'b1;
        @(negedge i_core_clk);
        i_op_done = 1'b0;
        check("after done", 20'hC, 20'(o_status));
        host_u.frame(OPC_RESUME, 1'b0);
        wait_for(1, 300, 1'b1);
        check("resume kind", 20'(OP_ERASE_SECTOR), 20'(o_resume_desc.kind));
        check("resume status", 20'h0, 20'(o_status));
        repeat (210) @(negedge i_core_clk);
        susp(20'hC);
        i_sw_reset = 1'b1;
        @(negedge i_core_clk);
        i_sw_reset = 1'b0;
        check("sw abort", 20'h53, 20'({o_lost_erase, o_lost_prog, o_lost_erase_region.whole_sector,
            o_lost_erase_region.sector}));
        check("status", 20'h8, 20'(o_status));
        start(OP_ERASE_PAGE, 4'h6, 12'h123);
        susp(20'hC);
        start(OP_PROG_B2, 4'h7, 12'h055);
        susp(20'hE);
        i_reset_pin_n = 1'b0;
        wait_for(2, 20, 1'b1);
        check("pin region", 20'h06123, 20'(o_lost_erase_region));
        check("pin prog", 20'h27055, 20'({o_lost_prog, o_lost_prog_region}));
        i_reset_pin_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        check("status", 20'h8, 20'(o_status));
        test_done();
    end
endmodule

bind pesc_ctrl pesc_chk #(.SUSP_CYC(SUSP_CYC), .RES_CYC(RES_CYC)) chk_u (.i_core_clk,
    .i_rst_n, .i_cmd_valid, .i_cmd_class, .o_cmd_accept, .o_cmd_reject, .o_prog_abort,
    .o_rd_undefined, .o_op_halt, .o_op_resume, .o_resume_desc, .o_status, .o_lost_erase,
    .o_lost_prog);
